// [alu_branch_pkg.sv]
// How it works
// - sum and sum-with-carry of two working registers write the destination in one cycle and update Z,C,N,V,H.
// - word immediate sum/diff on a low register and its high partner take two cycles and update Z,C,N,V,S.
// - register subtract and borrow subtract write the destination in one cycle and update Z,C,N,V,H.
// - constant subtract, with or without borrow, writes the destination in one cycle and updates Z,C,N,V,H.
// - AND with a register or a constant takes one cycle, updates only Z,N,V and leaves carry alone.
// - OR with a register or constant, or XOR of two registers, takes one cycle and updates only Z,N,V.
// - bit set by mask ORs the constant into the destination in one cycle, updating only Z,N,V.
// - bit clear by mask ANDs the destination with all-ones minus the mask, updating only Z,N,V.
// - increment, decrement, self-AND test and self-XOR clear take one cycle on Z,N,V; fill-ones touches no flag.
// - indirect jump loads the PC from the pointer pair in two cycles; indirect call pushes and takes three; no flags.
// - equal skip steps over the next one- or two-word instruction when both registers match, in 1/2/3 cycles.
// - compares form destination minus register, minus register and carry, or minus constant, flags only, one cycle.
// - register bit skips step over the next instruction on a clear or set bit, in 1/2/3 cycles, no flags.
// - the I/O bit skip steps over the next instruction when the I/O bit reads zero, in 1/2/3 cycles, no flags.
package alu_branch_pkg;

  // ----------------------------------------
  // sizes and reset values
  // ----------------------------------------
  localparam int PC_W = 16;
  localparam int STACK_DEPTH = 16;
  localparam int REG_COUNT = 32;
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [7:0] SREG_RESET = 8'h00;
  localparam logic [7:0] ALL_ONES = 8'hFF;
  localparam logic [4:0] PTR_LOW_REG = 5'h1E;
  localparam logic [4:0] PTR_HIGH_REG = 5'h1F;

  // ----------------------------------------
  // status flag positions
  // ----------------------------------------
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;
  localparam int FLAG_I = 7;
  localparam logic [7:0] MASK_ARITH = 8'h2F;
  localparam logic [7:0] MASK_LOGIC = 8'h0E;
  localparam logic [7:0] MASK_WORD = 8'h1F;
  localparam logic [7:0] MASK_NONE = 8'h00;
  localparam logic [7:0] MASK_IRET = 8'h80;

  // ----------------------------------------
  // cycle counts
  // ----------------------------------------
  localparam logic [2:0] CYC_SINGLE = 3'h1;
  localparam logic [2:0] CYC_WORD = 3'h2;
  localparam logic [2:0] CYC_JUMP = 3'h2;
  localparam logic [2:0] CYC_CALL = 3'h3;
  localparam logic [2:0] CYC_RETURN = 3'h4;
  localparam logic [2:0] CYC_SKIP_SHORT = 3'h2;
  localparam logic [2:0] CYC_SKIP_LONG = 3'h3;

  typedef enum logic [5:0] {
    OP_NOP, OP_SUM, OP_SUM_CARRY, OP_WORD_IMMEDIATE_SUM, OP_DIFF, OP_SUBTRACT_CONST,
    OP_BORROW_SUBTRACT, OP_BORROW_SUBTRACT_CONST, OP_WORD_IMMEDIATE_DIFF, OP_CONJ,
    OP_CONJUNCT_CONST, OP_DISJ, OP_DISJUNCT_CONST, OP_XOR_REGS, OP_BIT_SET_MASK,
    OP_BIT_CLEAR_MASK, OP_INCR, OP_DECR, OP_ZERO_SIGN_TEST, OP_ZERO_REG, OP_REG_FILL_ONES,
    OP_RELATIVE_JUMP, OP_INDIRECT_JUMP, OP_RELATIVE_SUBROUTINE_CALL,
    OP_INDIRECT_SUBROUTINE_CALL, OP_SUB_RETURN, OP_INTERRUPT_RETURN, OP_EQUAL_SKIP,
    OP_COMPARE, OP_COMPARE_WITH_BORROW, OP_COMPARE_CONST, OP_REG_BIT_CLEAR_SKIP,
    OP_REG_BIT_SET_SKIP, OP_IO_BIT_CLEAR_SKIP
  } op_t;

  typedef enum logic [2:0] {
    ALU_ADD, ALU_ADC, ALU_SUB, ALU_SUBB, ALU_AND, ALU_OR, ALU_XOR, ALU_INC_DEC
  } alu_mode_t;

  typedef enum logic {ST_IDLE = 1'b0, ST_WAIT = 1'b1} state_t;

  typedef struct packed {
    op_t op;
    logic [4:0] dst;
    logic [4:0] src;
    logic [7:0] imm;
    logic [11:0] offset;
    logic [2:0] bitSel;
  } instr_t;

  typedef struct packed {
    logic h;
    logic v;
    logic n;
    logic z;
    logic c;
  } flags_t;

  typedef struct packed {
    logic en;
    logic [4:0] addr;
    logic [7:0] data;
  } store_t;

endpackage

// [alu_unit.sv]
module alu_unit
  import alu_branch_pkg::*;
(
  input wire alu_mode_t mode,
  input wire logic subtract,
  input wire logic [7:0] opA,
  input wire logic [7:0] opB,
  input wire logic carryIn,
  input wire logic zeroIn,
  output logic [7:0] result,
  output flags_t flags
);

  // ----------------------------------------
  // adder and logic
  // ----------------------------------------
  // one 9-bit adder serves add, subtract and inc/dec; bit 8 is carry or borrow
  wire logic useCarry = (mode == ALU_ADC || mode == ALU_SUBB) & carryIn;
  wire logic [8:0] extra = {8'h00, useCarry};
  wire logic [8:0] sum9 = subtract ? ({1'b0, opA} - {1'b0, opB} - extra)
                                   : ({1'b0, opA} + {1'b0, opB} + extra);
  wire logic isLogic = (mode == ALU_AND || mode == ALU_OR || mode == ALU_XOR);
  wire logic [7:0] logicRes = (mode == ALU_AND) ? (opA & opB) :
                              (mode == ALU_OR) ? (opA | opB) : (opA ^ opB);
  wire logic [7:0] r = isLogic ? logicRes : sum9[7:0];
  wire logic halfAdd = (opA[3] & opB[3]) | (opB[3] & ~r[3]) | (~r[3] & opA[3]);
  wire logic halfSub = (~opA[3] & opB[3]) | (opB[3] & r[3]) | (r[3] & ~opA[3]);
  wire logic ovfAdd = (opA[7] & opB[7] & ~r[7]) | (~opA[7] & ~opB[7] & r[7]);
  wire logic ovfSub = (opA[7] & ~opB[7] & ~r[7]) | (~opA[7] & opB[7] & r[7]);
  // borrow forms keep Z clear once an earlier byte was non-zero
  wire logic zeroChain = (mode == ALU_SUBB) ? zeroIn : 1'b1;

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign result = r;
  assign flags.h = subtract ? halfSub : halfAdd;
  assign flags.v = isLogic ? 1'b0 : (subtract ? ovfSub : ovfAdd);
  assign flags.n = r[7];
  assign flags.z = (r == 8'h00) & zeroChain;
  assign flags.c = sum9[8];

endmodule // alu_unit

// [mcu_alu_branch_core.sv]
module mcu_alu_branch_core
  import alu_branch_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic instrValid,
  input wire instr_t instr,
  input wire logic nextIsLong,
  input wire logic ioBitIn,
  input wire store_t preload,
  output logic instrReady_r,
  output logic [PC_W-1:0] pc_r,
  output logic [7:0] sreg_r,
  output store_t store_r,
  output logic retireValid_r,
  output logic [2:0] retireCycles_r
);

  // ----------------------------------------
  // storage
  // ----------------------------------------
  logic [7:0] regFile [REG_COUNT];
  logic [PC_W-1:0] stack [STACK_DEPTH];
  logic [$clog2(STACK_DEPTH)-1:0] sp_r;
  state_t state_r;
  logic [2:0] remain_r;

  // ----------------------------------------
  // decode helpers
  // ----------------------------------------
  function automatic alu_mode_t aluModeOf(input op_t op);
    case (op)
      OP_SUM: aluModeOf = ALU_ADD;
      OP_SUM_CARRY: aluModeOf = ALU_ADC;
      OP_BORROW_SUBTRACT, OP_BORROW_SUBTRACT_CONST, OP_COMPARE_WITH_BORROW: aluModeOf = ALU_SUBB;
      OP_CONJ, OP_CONJUNCT_CONST, OP_BIT_CLEAR_MASK, OP_ZERO_SIGN_TEST: aluModeOf = ALU_AND;
      OP_DISJ, OP_DISJUNCT_CONST, OP_BIT_SET_MASK: aluModeOf = ALU_OR;
      OP_XOR_REGS, OP_ZERO_REG: aluModeOf = ALU_XOR;
      OP_INCR, OP_DECR: aluModeOf = ALU_INC_DEC;
      default: aluModeOf = ALU_SUB;
    endcase
  endfunction

  // which flags each instruction may touch; the rest keep their value
  function automatic logic [7:0] flagMaskOf(input op_t op);
    case (op)
      OP_SUM, OP_SUM_CARRY, OP_DIFF, OP_SUBTRACT_CONST, OP_BORROW_SUBTRACT,
      OP_BORROW_SUBTRACT_CONST, OP_COMPARE, OP_COMPARE_WITH_BORROW,
      OP_COMPARE_CONST: flagMaskOf = MASK_ARITH;
      OP_CONJ, OP_CONJUNCT_CONST, OP_DISJ, OP_DISJUNCT_CONST, OP_XOR_REGS,
      OP_BIT_SET_MASK, OP_BIT_CLEAR_MASK, OP_INCR, OP_DECR, OP_ZERO_SIGN_TEST,
      OP_ZERO_REG: flagMaskOf = MASK_LOGIC;
      OP_WORD_IMMEDIATE_SUM, OP_WORD_IMMEDIATE_DIFF: flagMaskOf = MASK_WORD;
      OP_INTERRUPT_RETURN: flagMaskOf = MASK_IRET;
      default: flagMaskOf = MASK_NONE;
    endcase
  endfunction

  // ----------------------------------------
  // operand fetch and decode
  // ----------------------------------------
  wire logic accept = instrValid & instrReady_r;
  wire op_t op = instr.op;
  wire logic [7:0] dstVal = regFile[instr.dst];
  wire logic [7:0] srcVal = regFile[instr.src];
  wire logic [4:0] hiAddr = instr.dst + 5'h01;
  wire logic [15:0] wordVal = {regFile[hiAddr], dstVal};
  wire logic [15:0] ptrVal = {regFile[PTR_HIGH_REG], regFile[PTR_LOW_REG]};
  wire logic useImm = op == OP_SUBTRACT_CONST || op == OP_BORROW_SUBTRACT_CONST ||
                      op == OP_CONJUNCT_CONST || op == OP_DISJUNCT_CONST ||
                      op == OP_BIT_SET_MASK || op == OP_COMPARE_CONST;
  wire logic selfOp = op == OP_ZERO_SIGN_TEST || op == OP_ZERO_REG;
  wire logic isIncDec = op == OP_INCR || op == OP_DECR;
  // mask complement is all-ones minus the constant
  wire logic [7:0] clearMask = ALL_ONES - instr.imm;
  wire logic [7:0] operandB = (op == OP_BIT_CLEAR_MASK) ? clearMask :
                              useImm ? instr.imm : selfOp ? dstVal :
                              isIncDec ? 8'h01 : srcVal;
  wire logic isSubtract = op == OP_DIFF || op == OP_SUBTRACT_CONST || op == OP_BORROW_SUBTRACT ||
                          op == OP_BORROW_SUBTRACT_CONST || op == OP_COMPARE ||
                          op == OP_COMPARE_WITH_BORROW || op == OP_COMPARE_CONST ||
                          op == OP_DECR;
  wire logic isCompare = op == OP_COMPARE || op == OP_COMPARE_WITH_BORROW ||
                         op == OP_COMPARE_CONST;
  wire logic isWord = op == OP_WORD_IMMEDIATE_SUM || op == OP_WORD_IMMEDIATE_DIFF;
  wire logic [7:0] flagMask = flagMaskOf(op);
  wire logic writesByte = (flagMask == MASK_ARITH || flagMask == MASK_LOGIC ||
                           op == OP_REG_FILL_ONES) && !isCompare;
  logic [7:0] aluResult;
  flags_t aluFlags;

  alu_unit u_alu (
    .mode(aluModeOf(op)),
    .subtract(isSubtract),
    .opA(dstVal),
    .opB(operandB),
    .carryIn(sreg_r[FLAG_C]),
    .zeroIn(sreg_r[FLAG_Z]),
    .result(aluResult),
    .flags(aluFlags)
  );

  // ----------------------------------------
  // word immediate arithmetic
  // ----------------------------------------
  wire logic [15:0] wordRes = (op == OP_WORD_IMMEDIATE_DIFF) ? wordVal - {8'h00, instr.imm}
                                                             : wordVal + {8'h00, instr.imm};
  wire logic wordV = (op == OP_WORD_IMMEDIATE_DIFF) ? (wordVal[15] & ~wordRes[15])
                                                    : (~wordVal[15] & wordRes[15]);
  wire logic wordC = (op == OP_WORD_IMMEDIATE_DIFF) ? (wordRes[15] & ~wordVal[15])
                                                    : (~wordRes[15] & wordVal[15]);
  // bit order {I,T,H,S,V,N,Z,C}
  wire logic [7:0] wordFlags = {3'b000, wordRes[15] ^ wordV, wordV, wordRes[15],
                                wordRes == 16'h0000, wordC};
  wire logic [7:0] byteFlags = {1'b1, 1'b0, aluFlags.h, 1'b0, aluFlags.v, aluFlags.n,
                                aluFlags.z, aluFlags.c};
  wire logic [7:0] newFlags = isWord ? wordFlags : byteFlags;
  // untouched flags hold
  wire logic [7:0] sregNxt = (sreg_r & ~flagMask) | (newFlags & flagMask);
  wire logic [7:0] byteResult = (op == OP_REG_FILL_ONES) ? ALL_ONES : aluResult;

  // ----------------------------------------
  // skip and branch targets
  // ----------------------------------------
  wire logic [PC_W-1:0] pcNext1 = pc_r + 16'h0001;
  wire logic [PC_W-1:0] relTarget = pc_r + PC_W'(signed'(instr.offset)) + 16'h0001;
  wire logic selBit = dstVal[instr.bitSel];
  wire logic skipHit = (op == OP_EQUAL_SKIP && dstVal == srcVal) ||
                       (op == OP_REG_BIT_CLEAR_SKIP && !selBit) ||
                       (op == OP_REG_BIT_SET_SKIP && selBit) ||
                       (op == OP_IO_BIT_CLEAR_SKIP && !ioBitIn);
  wire logic [PC_W-1:0] skipTarget = nextIsLong ? pc_r + 16'h0003 : pc_r + 16'h0002;
  wire logic [2:0] skipCycles = !skipHit ? CYC_SINGLE : nextIsLong ? CYC_SKIP_LONG
                                                                   : CYC_SKIP_SHORT;
  wire logic isCall = op == OP_RELATIVE_SUBROUTINE_CALL || op == OP_INDIRECT_SUBROUTINE_CALL;
  wire logic isReturn = op == OP_SUB_RETURN || op == OP_INTERRUPT_RETURN;
  wire logic [$clog2(STACK_DEPTH)-1:0] spDown = sp_r - 1'b1;
  wire logic [PC_W-1:0] pcNxt =
      (op == OP_RELATIVE_JUMP || op == OP_RELATIVE_SUBROUTINE_CALL) ? relTarget :
      (op == OP_INDIRECT_JUMP || op == OP_INDIRECT_SUBROUTINE_CALL) ? ptrVal :
      isReturn ? stack[spDown] : skipHit ? skipTarget : pcNext1;
  wire logic [2:0] cyclesNxt =
      isWord ? CYC_WORD :
      (op == OP_RELATIVE_JUMP || op == OP_INDIRECT_JUMP) ? CYC_JUMP :
      isCall ? CYC_CALL : isReturn ? CYC_RETURN : skipCycles;

  // ----------------------------------------
  // working registers and stack
  // ----------------------------------------
  // arrays carry no reset; software must load a register before reading it
  always_ff @(posedge core_clk) begin
    if (accept && writesByte) begin
      regFile[instr.dst] <= byteResult;
    end else if (accept && isWord) begin
      regFile[instr.dst] <= wordRes[7:0];
      regFile[hiAddr] <= wordRes[15:8];
    end else if (instrReady_r && !instrValid && preload.en) begin
      regFile[preload.addr] <= preload.data;
    end
    if (accept && isCall) begin
      stack[sp_r] <= pcNext1;
    end
  end

  // ----------------------------------------
  // program counter, flags and sequencing
  // ----------------------------------------
  // effects land on the edge that takes the instruction; the wait only pads cycles
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pc_r <= PC_RESET;
      sreg_r <= SREG_RESET;
      sp_r <= '0;
      state_r <= ST_IDLE;
      remain_r <= 3'h0;
      instrReady_r <= 1'b1;
      store_r <= '0;
      retireValid_r <= 1'b0;
      retireCycles_r <= 3'h0;
    end else begin
      retireValid_r <= accept;
      store_r.en <= accept && (writesByte || isWord);
      if (accept) begin
        pc_r <= pcNxt;
        sreg_r <= sregNxt;
        store_r.addr <= instr.dst;
        store_r.data <= isWord ? wordRes[7:0] : byteResult;
        retireCycles_r <= cyclesNxt;
        if (isCall) begin
          sp_r <= sp_r + 1'b1;
        end else if (isReturn) begin
          sp_r <= spDown;
        end
      end
      case (state_r)
        ST_IDLE: begin
          if (accept && cyclesNxt != CYC_SINGLE) begin
            state_r <= ST_WAIT;
            remain_r <= cyclesNxt - 3'h2;
            instrReady_r <= 1'b0;
          end
        end
        ST_WAIT: begin
          if (remain_r == 3'h0) begin
            state_r <= ST_IDLE;
            instrReady_r <= 1'b1;
          end else begin
            remain_r <= remain_r - 3'h1;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_sum_result: assert property (@(posedge core_clk) disable iff (rst)
    accept && op == OP_SUM |=> store_r.data == $past(dstVal) + $past(srcVal))
    else $error("register sum wrong");
  a_word_latency: assert property (@(posedge core_clk) disable iff (rst)
    accept && isWord |=> !instrReady_r ##1 instrReady_r)
    else $error("word op not two cycles");
  a_diff_result: assert property (@(posedge core_clk) disable iff (rst)
    accept && op == OP_DIFF |=> store_r.data == $past(dstVal) - $past(srcVal) && store_r.en)
    else $error("register difference wrong");
  a_conj_carry: assert property (@(posedge core_clk) disable iff (rst)
    accept && op == OP_CONJ |=> sreg_r[FLAG_C] == $past(sreg_r[FLAG_C]) && !sreg_r[FLAG_V])
    else $error("and touched carry");
  a_fill_noflags: assert property (@(posedge core_clk) disable iff (rst)
    accept && op == OP_REG_FILL_ONES |=> sreg_r == $past(sreg_r) && store_r.data == ALL_ONES)
    else $error("fill ones wrong");
  a_ijump_target: assert property (@(posedge core_clk) disable iff (rst)
    accept && op == OP_INDIRECT_JUMP |=> pc_r == $past(ptrVal) && !instrReady_r)
    else $error("indirect jump target wrong");
  a_equal_skip: assert property (@(posedge core_clk) disable iff (rst)
    accept && op == OP_EQUAL_SKIP && dstVal == srcVal && !nextIsLong
    |=> pc_r == $past(pc_r) + 16'h0002 && retireCycles_r == CYC_SKIP_SHORT)
    else $error("equal skip wrong");
  a_compare_nowrite: assert property (@(posedge core_clk) disable iff (rst)
    accept && isCompare |=> !store_r.en && instrReady_r)
    else $error("compare wrote a register");
  a_bit_skip: assert property (@(posedge core_clk) disable iff (rst)
    accept && op == OP_REG_BIT_SET_SKIP && !selBit |=> pc_r == $past(pc_r) + 16'h0001)
    else $error("bit skip taken wrongly");
  a_io_skip: assert property (@(posedge core_clk) disable iff (rst)
    accept && op == OP_IO_BIT_CLEAR_SKIP && !ioBitIn && nextIsLong
    |=> pc_r == $past(pc_r) + 16'h0003 ##1 !instrReady_r ##1 instrReady_r)
    else $error("io bit skip wrong");
  a_call_latency: assert property (@(posedge core_clk) disable iff (rst)
    accept && op == OP_RELATIVE_SUBROUTINE_CALL |=> !instrReady_r [*2] ##1 instrReady_r)
    else $error("relative call not three cycles");

endmodule // mcu_alu_branch_core

// [program_feed_model.sv]
module program_feed_model
  import alu_branch_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic offer,
  input wire instr_t offerInstr,
  input wire logic offerLong,
  input wire logic offerIo,
  input wire logic instrReady_r,
  output logic instrValid,
  output instr_t instr,
  output logic nextIsLong,
  output logic ioBitIn
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // fetch word holder
  // ----------------------------------------
  // word holds until taken; then lines flip so stale data is never trusted
  always_ff @(posedge core_clk) begin
    if (rst) begin
      instrValid <= 1'b0;
      instr <= '0;
      nextIsLong <= 1'b0;
      ioBitIn <= 1'b0;
    end else if (offer) begin
      instrValid <= 1'b1;
      instr <= offerInstr;
      nextIsLong <= offerLong;
      ioBitIn <= offerIo;
    end else if (instrValid && instrReady_r) begin
      instrValid <= 1'b0;
      instr <= instr_t'(~instr);
      nextIsLong <= ~nextIsLong;
      ioBitIn <= ~ioBitIn;
    end
  end
endmodule // program_feed_model

// [mcu_alu_branch_core_tb.sv]
module mcu_alu_branch_core_tb
  import alu_branch_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // signals and bench state
  // ----------------------------------------
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic offer = 1'b0;
  instr_t offerInstr = '0;
  logic offerLong = 1'b0;
  logic offerIo = 1'b0;
  store_t preload = '0;
  logic instrValid, nextIsLong, ioBitIn, instrReady_r, retireValid_r;
  instr_t instr;
  logic [15:0] pc_r;
  logic [7:0] sreg_r;
  store_t store_r, st;
  logic [2:0] retireCycles_r;
  logic [15:0] pcNow = 16'h0000;
  logic [7:0] sr = 8'h00;
  int errors = 0;
  int nCompared = 0;
  mcu_alu_branch_core u_dut (.core_clk(core_clk), .rst(rst), .instrValid(instrValid),
    .instr(instr), .nextIsLong(nextIsLong), .ioBitIn(ioBitIn), .preload(preload),
    .instrReady_r(instrReady_r), .pc_r(pc_r), .sreg_r(sreg_r), .store_r(store_r),
    .retireValid_r(retireValid_r), .retireCycles_r(retireCycles_r));
  program_feed_model u_mem (.core_clk(core_clk), .rst(rst), .offer(offer),
    .offerInstr(offerInstr), .offerLong(offerLong), .offerIo(offerIo),
    .instrReady_r(instrReady_r), .instrValid(instrValid), .instr(instr),
    .nextIsLong(nextIsLong), .ioBitIn(ioBitIn));
  // free-running core clock, 8 ns
  initial forever #4 core_clk = ~core_clk;
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic summarize();
    $display("compared %0d errors %0d", nCompared, errors);
    if (errors == 0 && nCompared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
    nCompared++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp, input string what);
    chk8(got[15:8], exp[15:8], what);
    chk8(got[7:0], exp[7:0], what);
  endtask
  task automatic chkSt(input logic en, input logic [4:0] a, input logic [7:0] d);
    chk8({7'h00, st.en}, {7'h00, en}, "store en");
    if (en) begin
      chk8({3'h0, st.addr}, {3'h0, a}, "store addr");
      chk8(st.data, d, "store data");
    end
  endtask
  function automatic instr_t mk(input op_t o, input logic [4:0] d, input logic [4:0] s,
                                input logic [7:0] k);
    mk = '{op: o, dst: d, src: s, imm: k, offset: 12'h000, bitSel: 3'h0};
  endfunction
  // working registers are not reset, so every scenario loads what it reads
  task automatic pre(input logic [4:0] a, input logic [7:0] d);
    @(posedge core_clk);
    #1;
    preload = '{en: 1'b1, addr: a, data: d};
    @(posedge core_clk);
    #1;
    preload.en = 1'b0;
  endtask
  // one instruction: pc, status and count at retire, then the busy span
  task automatic exec(input instr_t i, input logic lng, input logic io,
                      input logic [15:0] ePc, input logic [2:0] eCyc);
    int n;
    @(posedge core_clk);
    #1;
    offer = 1'b1;
    offerInstr = i;
    offerLong = lng;
    offerIo = io;
    @(posedge core_clk);
    #1;
    offer = 1'b0;
    n = 0;
    while (retireValid_r !== 1'b1 && n < 10) begin
      @(negedge core_clk);
      n++;
    end
    st = store_r;
    chk16(pc_r, ePc, "pc");
    chk8(sreg_r, sr, "status");
    chk8({5'h00, retireCycles_r}, {5'h00, eCyc}, "cycles");
    n = 0;
    while (instrReady_r !== 1'b1 && n < 8) begin
      @(negedge core_clk);
      n++;
    end
    chk8(8'(n), {5'h00, eCyc} - 8'h01, "busy span");
    pcNow = ePc;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_add();
    pre(5'h01, 8'h0F);
    pre(5'h02, 8'hFF);
    sr = 8'h20;
    exec(mk(OP_SUM, 5'h01, 5'h01, 8'h00), 1'b0, 1'b0, pcNow + 16'h0001, CYC_SINGLE);
    chkSt(1'b1, 5'h01, 8'h1E);
    sr = 8'h21;
    exec(mk(OP_SUM, 5'h02, 5'h01, 8'h00), 1'b0, 1'b0, pcNow + 16'h0001, CYC_SINGLE);
    chkSt(1'b1, 5'h02, 8'h1D);
    sr = 8'h20;
    exec(mk(OP_SUM_CARRY, 5'h01, 5'h01, 8'h00), 1'b0, 1'b0, pcNow + 16'h0001, 3'h1);
    chkSt(1'b1, 5'h01, 8'h3D);
  endtask
  task automatic t_sub();
    pre(5'h07, 8'h10);
    pre(5'h08, 8'h01);
    pre(5'h09, 8'h0E);
    sr = 8'h25;
    exec(mk(OP_SUBTRACT_CONST, 5'h07, 5'h00, 8'h11), 1'b0, 1'b0, pcNow + 16'h0001, 3'h1);
    chkSt(1'b1, 5'h07, 8'hFF);
    sr = 8'h04;
    exec(mk(OP_BORROW_SUBTRACT_CONST, 5'h07, 5'h00, 8'h00), 1'b0, 1'b0, pcNow + 16'h0001, 3'h1);
    chkSt(1'b1, 5'h07, 8'hFE);
    exec(mk(OP_BORROW_SUBTRACT, 5'h07, 5'h08, 8'h00), 1'b0, 1'b0, pcNow + 16'h0001, 3'h1);
    chkSt(1'b1, 5'h07, 8'hFD);
    sr = 8'h24;
    exec(mk(OP_DIFF, 5'h07, 5'h09, 8'h00), 1'b0, 1'b0, pcNow + 16'h0001, 3'h1);
    chkSt(1'b1, 5'h07, 8'hEF);
  endtask
  // half carry set beforehand must survive every word op
  task automatic t_word();
    pre(5'h18, 8'hFF);
    pre(5'h19, 8'h7F);
    pre(5'h1A, 8'h00);
    pre(5'h1B, 8'h00);
    sr = 8'h2C;
    exec(mk(OP_WORD_IMMEDIATE_SUM, 5'h18, 5'h00, 8'h01), 1'b0, 1'b0, pcNow + 16'h0001, CYC_WORD);
    chkSt(1'b1, 5'h18, 8'h00);
    sr = 8'h38;
    exec(mk(OP_WORD_IMMEDIATE_DIFF, 5'h18, 5'h00, 8'h01), 1'b0, 1'b0, pcNow + 16'h0001, 3'h2);
    chkSt(1'b1, 5'h18, 8'hFF);
    sr = 8'h35;
    exec(mk(OP_WORD_IMMEDIATE_DIFF, 5'h1A, 5'h00, 8'h01), 1'b0, 1'b0, pcNow + 16'h0001, 3'h2);
    sr = 8'h23;
    exec(mk(OP_WORD_IMMEDIATE_SUM, 5'h1A, 5'h00, 8'h01), 1'b0, 1'b0, pcNow + 16'h0001, 3'h2);
  endtask
  task automatic t_logic();
    op_t ops[12] = '{OP_CONJ, OP_CONJUNCT_CONST, OP_DISJ, OP_DISJUNCT_CONST, OP_XOR_REGS,
      OP_BIT_SET_MASK, OP_BIT_CLEAR_MASK, OP_ZERO_SIGN_TEST, OP_ZERO_REG, OP_REG_FILL_ONES,
      OP_INCR, OP_DECR};
    logic [7:0] res[12] = '{8'h30, 8'h00, 8'hFC, 8'hFF, 8'hCC, 8'hFF, 8'hF0, 8'hF0, 8'h00,
      8'hFF, 8'hF1, 8'hEF};
    pre(5'h0A, 8'h00);
    pre(5'h0C, 8'h3C);
    sr = 8'h02;
    exec(mk(OP_COMPARE, 5'h0A, 5'h0A, 8'h00), 1'b0, 1'b0, pcNow + 16'h0001, 3'h1);
    sr = 8'h25;
    exec(mk(OP_COMPARE_CONST, 5'h0A, 5'h00, 8'h01), 1'b0, 1'b0, pcNow + 16'h0001, 3'h1);
    exec(mk(OP_COMPARE_WITH_BORROW, 5'h0A, 5'h0C, 8'hC3), 1'b0, 1'b0, pcNow + 16'h0001, 3'h1);
    chkSt(1'b0, 5'h00, 8'h00);
    // carry and half carry stay set across the whole table
    for (int k = 0; k < 12; k++) begin
      pre(5'h0B, 8'hF0);
      if (ops[k] != OP_REG_FILL_ONES) begin
        sr = {sr[7:4], 1'b0, res[k][7], res[k] == 8'h00, sr[0]};
      end
      exec(mk(ops[k], 5'h0B, 5'h0C, 8'h0F), 1'b0, 1'b0, pcNow + 16'h0001, 3'h1);
      chkSt(1'b1, 5'h0B, res[k]);
    end
  endtask
  task automatic t_jump();
    instr_t i;
    logic [15:0] back1, back2;
    i = mk(OP_RELATIVE_JUMP, 5'h00, 5'h00, 8'h00);
    i.offset = 12'hFFE;
    exec(i, 1'b0, 1'b0, pcNow - 16'h0001, CYC_JUMP);
    i.op = OP_RELATIVE_SUBROUTINE_CALL;
    i.offset = 12'h010;
    back1 = pcNow + 16'h0001;
    exec(i, 1'b0, 1'b0, pcNow + 16'h0011, CYC_CALL);
    pre(PTR_LOW_REG, 8'h34);
    pre(PTR_HIGH_REG, 8'h12);
    back2 = pcNow + 16'h0001;
    exec(mk(OP_INDIRECT_SUBROUTINE_CALL, 5'h00, 5'h00, 8'h00), 1'b0, 1'b0, 16'h1234, 3'h3);
    exec(mk(OP_SUB_RETURN, 5'h00, 5'h00, 8'h00), 1'b0, 1'b0, back2, CYC_RETURN);
    sr = sr | 8'h80;
    exec(mk(OP_INTERRUPT_RETURN, 5'h00, 5'h00, 8'h00), 1'b0, 1'b0, back1, 3'h4);
    exec(mk(OP_INDIRECT_JUMP, 5'h00, 5'h00, 8'h00), 1'b0, 1'b0, 16'h1234, 3'h2);
    // the idle op must leave flags, registers and flow alone
    exec(mk(OP_NOP, 5'h00, 5'h00, 8'h00), 1'b0, 1'b0, 16'h1235, CYC_SINGLE);
    chkSt(1'b0, 5'h00, 8'h00);
  endtask
  // skip distance equals cycle count in every case of the table
  task automatic t_skip();
    instr_t i;
    op_t sk[10] = '{OP_EQUAL_SKIP, OP_EQUAL_SKIP, OP_EQUAL_SKIP, OP_REG_BIT_CLEAR_SKIP,
      OP_REG_BIT_CLEAR_SKIP, OP_REG_BIT_SET_SKIP, OP_REG_BIT_SET_SKIP, OP_IO_BIT_CLEAR_SKIP,
      OP_IO_BIT_CLEAR_SKIP, OP_IO_BIT_CLEAR_SKIP};
    logic [4:0] src[10] = '{5'h0F, 5'h0E, 5'h0E, 5'h0, 5'h0, 5'h0, 5'h0, 5'h0, 5'h0, 5'h0};
    logic [2:0] bsel[10] = '{3'h0, 3'h0, 3'h0, 3'h2, 3'h3, 3'h2, 3'h0, 3'h0, 3'h0, 3'h0};
    logic [2:0] cyc[10] = '{3'h1, 3'h2, 3'h3, 3'h1, 3'h3, 3'h2, 3'h1, 3'h2, 3'h1, 3'h3};
    logic [9:0] lng = 10'b10_0001_0100;
    logic [9:0] io = 10'b01_0000_0000;
    pre(5'h0D, 8'h04);
    pre(5'h0E, 8'h04);
    pre(5'h0F, 8'h05);
    for (int k = 0; k < 10; k++) begin
      i = mk(sk[k], 5'h0D, src[k], 8'h00);
      i.bitSel = bsel[k];
      exec(i, lng[k], io[k], pcNow + {13'h0000, cyc[k]}, cyc[k]);
      chkSt(1'b0, 5'h00, 8'h00);
    end
  endtask
  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial begin
    repeat (16) @(posedge core_clk);
    #1;
    rst = 1'b0;
    chk16(pc_r, PC_RESET, "reset pc");
    t_add();
    t_sub();
    t_word();
    t_logic();
    t_jump();
    t_skip();
    summarize();
  end
  // the whole run needs well under a thousand cycles
  initial begin
    repeat (4000) @(posedge core_clk);
    errors++;
    summarize();
  end
endmodule // mcu_alu_branch_core_tb
